// ---- sus_pkg.sv ----
//**********************************************************************
// Purpose: Constants for the asynchronous serial transceiver
// Assumes: Register index map on a plain strobe port, 8-bit data
// Notes:   Offsets are register indices; data sits in the low byte
//**********************************************************************
package sus_pkg;
  // Register indices
  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_LINE   = 3'h1;
  localparam logic [2:0] ADDR_DIR    = 3'h2;
  localparam logic [2:0] ADDR_WIRE   = 3'h3;
  localparam logic [2:0] ADDR_DATA   = 3'h4;
  localparam logic [2:0] ADDR_BAUD   = 3'h5;
  // Status bit positions
  localparam int ST_PARITY_ERROR_FLAG  = 7;
  localparam int ST_NOISE = 6;
  localparam int ST_FRAMING_ERROR_FLAG  = 5;
  localparam int ST_OVERRUN_ERROR_FLAG  = 4;
  localparam int ST_RECEIVER_IDLE_FLAG = 3;
  localparam int ST_RDY   = 2;
  localparam int ST_TRANSMIT_IDLE_FLAG = 1;
  localparam int ST_TEMPTY = 0;
  // Line format bit positions
  localparam int LF_EN    = 7;
  localparam int LF_NINE  = 6;
  localparam int LF_PEN   = 5;
  localparam int LF_ODD   = 4;
  localparam int LF_STOP2 = 3;
  localparam int LF_BRK   = 2;
  localparam int LF_RX8   = 1;
  localparam int LF_TX8   = 0;
  // Direction control bit positions
  localparam int DC_TRANSMITTER_ENABLE  = 7;
  localparam int DC_RECEIVER_ENABLE  = 6;
  localparam int DC_FAST  = 5;
  localparam int DC_ADDR  = 4;
  localparam int DC_RIE   = 2;
  localparam int DC_TIIE  = 1;
  localparam int DC_TEIE  = 0;
  // Reset values
  localparam logic [7:0] STATUS_RST = 8'h0b;
  localparam logic [7:0] CTRL_RST   = 8'h00;
  // Oversampling: 16 ticks a bit in slow mode, 4 in fast mode
  localparam logic [3:0] OVS_SLOW = 4'hf;
  localparam logic [3:0] OVS_FAST = 4'h3;
  localparam int BREAK_BITS = 13;
endpackage : sus_pkg

// ---- sus_uart.sv ----
//**********************************************************************
// Purpose: Asynchronous serial transceiver with single-wire option
// Assumes: Inputs synchronous to clock; register port never waits
// Notes:   Link pins split into in/out/output-enable (enable low = drive)
//**********************************************************************
`timescale 1ns/1ps
module sus_uart
  import sus_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_b,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Dedicated transmit pin
  output logic            tx_out,
  output logic            tx_oe_b,
  output logic            tx_pullup,
  // Shared receive/transmit pin
  input  wire logic       rxtx_in,
  output logic            rxtx_out,
  output logic            rxtx_oe_b,
  output logic            rxtx_pullup,
  // Event line
  output logic            irq
);
  // Pointers and count are sized for exactly two entries
  if (FIFO_DEPTH != 2) begin : g_depth_check
    $error("FIFO_DEPTH must be 2");
  end

  //********************************************************************
  // Registers and bus decode
  //********************************************************************
  logic [7:0] line_reg;           // Line format control
  logic [7:0] dir_reg;            // Direction and event control
  logic       wire_reg;           // Single-wire select
  logic [7:0] baud_reg;           // Baud divisor
  logic [7:0] st_reg;             // Flags (bits not live)
  logic       st_armed_reg;       // Status read seen
  logic [7:0] rdata_next;         // Read mux
  logic       en;                 // Overall enable
  logic       transmitter_enable;               // Transmitter live
  logic       receiver_enable;               // Receiver live
  logic       wr_data;            // Data write
  logic       rd_data;            // Data read
  logic       seq_clr;            // Status then data access
  logic       nine;               // Nine-bit format
  logic       disable_now;        // Overall enable being cleared
  assign en      = line_reg[LF_EN];
  assign transmitter_enable    = en & dir_reg[DC_TRANSMITTER_ENABLE];
  assign receiver_enable    = en & dir_reg[DC_RECEIVER_ENABLE];
  assign nine    = line_reg[LF_NINE];
  assign wr_data = reg_wr & (reg_addr == ADDR_DATA);
  assign rd_data = reg_rd & (reg_addr == ADDR_DATA);
  assign seq_clr = st_armed_reg & (wr_data | rd_data);
  assign disable_now = reg_wr & (reg_addr == ADDR_LINE) & ~reg_wdata[LF_EN];

  // Parity of a nine-bit word; odd select inverts it
  function automatic logic par_of(input logic [8:0] d, input logic nb, input logic odd);
    par_of = ^{d[8] & nb, d[7:0]} ^ odd;
  endfunction : par_of

  // Status read arms the clear sequence
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_armed_reg <= 1'b0;
    end else if (reg_rd & (reg_addr == ADDR_STATUS)) begin
      st_armed_reg <= 1'b1;
    end else if (wr_data | rd_data) begin
      st_armed_reg <= 1'b0;
    end
  end

  // Control registers; disabling clears the direction enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      line_reg <= CTRL_RST;
      dir_reg  <= CTRL_RST;
      wire_reg <= 1'b0;
      baud_reg <= CTRL_RST;
    end else begin
      if (reg_wr) begin
        unique case (reg_addr)
          // Receive ninth bit position is read-only
          ADDR_LINE: line_reg <= {reg_wdata[7:2], 1'b0, reg_wdata[LF_TX8]};
          ADDR_DIR:  dir_reg  <= reg_wdata;
          ADDR_WIRE: wire_reg <= reg_wdata[0];
          ADDR_BAUD: baud_reg <= reg_wdata;
          default:   ;
        endcase
      end
      if (disable_now | ~en) begin
        dir_reg[DC_TRANSMITTER_ENABLE] <= 1'b0;
        dir_reg[DC_RECEIVER_ENABLE] <= 1'b0;
        line_reg[LF_BRK] <= 1'b0;
      end
    end
  end

  //********************************************************************
  // Baud generator
  //********************************************************************
  logic [7:0] bcnt_reg;           // Prescaler down-counter
  logic       tick;               // Oversample tick
  logic [3:0] ovs_top;            // Ticks per bit minus one
  assign ovs_top = dir_reg[DC_FAST] ? OVS_FAST : OVS_SLOW;
  assign tick    = en & (bcnt_reg == 8'h00);
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bcnt_reg <= 8'h00;
    end else if (!en) begin
      bcnt_reg <= 8'h00;
    end else if (tick) begin
      bcnt_reg <= baud_reg;
    end else begin
      bcnt_reg <= bcnt_reg - 8'h01;
    end
  end

  //********************************************************************
  // Transmitter
  //********************************************************************
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_BREAK = 3'b100
  } sus_tx_t;
  sus_tx_t    tx_st_reg;          // Transmit state
  logic [7:0] thold_reg;          // Transmit holding byte
  logic       thold_full_reg;     // Holding byte queued
  logic [11:0] tsh_reg;           // Shifter incl. start/parity/stops
  logic [3:0] tbits_reg;          // Bits left
  logic [3:0] ttick_reg;          // Ticks within bit
  logic       tline_reg;          // Serial line level
  logic [4:0] brk_reg;            // Break bits sent
  logic       tx_load;            // Holding to shifter
  logic [3:0] frame_len;          // Bits in a frame incl. start
  logic       tpar;               // Transmit parity
  assign tpar = par_of({line_reg[LF_TX8], thold_reg}, nine, line_reg[LF_ODD]);
  assign frame_len = 4'd10 + {3'b000, nine} + {3'b000, line_reg[LF_PEN]}
                   + {3'b000, line_reg[LF_STOP2]};
  assign tx_load = (tx_st_reg == TX_IDLE) & thold_full_reg & transmitter_enable;

  // Holding byte fed by data writes
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      thold_reg      <= 8'h00;
      thold_full_reg <= 1'b0;
    end else if (!transmitter_enable) begin
      thold_full_reg <= 1'b0;
    end else if (wr_data) begin
      thold_reg      <= reg_wdata;
      thold_full_reg <= 1'b1;
    end else if (tx_load) begin
      thold_full_reg <= 1'b0;
    end
  end

  // Frame shifter and break generator
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tx_st_reg <= TX_IDLE;
      tsh_reg   <= 12'hfff;
      tbits_reg <= 4'h0;
      ttick_reg <= 4'h0;
      tline_reg <= 1'b1;
      brk_reg   <= 5'h00;
    end else if (!transmitter_enable) begin
      tx_st_reg <= TX_IDLE;
      tline_reg <= 1'b1;
    end else begin
      unique case (tx_st_reg)
        TX_IDLE: begin
          ttick_reg <= 4'h0;
          brk_reg   <= 5'h00;
          if (tx_load) begin
            tsh_reg <= nine ? {1'b1, line_reg[LF_PEN] ? tpar : 1'b1,
                               line_reg[LF_TX8], thold_reg, 1'b0}
                            : {2'b11, line_reg[LF_PEN] ? tpar : 1'b1, thold_reg, 1'b0};
            tbits_reg <= frame_len;
            tx_st_reg <= TX_SHIFT;
          end else if (line_reg[LF_BRK]) begin
            tx_st_reg <= TX_BREAK;
          end
        end
        TX_SHIFT: begin
          tline_reg <= tsh_reg[0];
          if (tick) begin
            ttick_reg <= ttick_reg + 4'h1;
            if (ttick_reg == ovs_top) begin
              ttick_reg <= 4'h0;
              tsh_reg   <= {1'b1, tsh_reg[11:1]};
              tbits_reg <= tbits_reg - 4'h1;
              if (tbits_reg == 4'h1) tx_st_reg <= TX_IDLE;
            end
          end
        end
        TX_BREAK: begin
          tline_reg <= 1'b0;
          if (tick) begin
            ttick_reg <= ttick_reg + 4'h1;
            if (ttick_reg == ovs_top) begin
              ttick_reg <= 4'h0;
              if (brk_reg != 5'(BREAK_BITS)) brk_reg <= brk_reg + 5'h01;
            end
          end
          if ((brk_reg == 5'(BREAK_BITS)) & ~line_reg[LF_BRK]) begin
            tx_st_reg <= TX_IDLE;
            tline_reg <= 1'b1;
          end
        end
        default: tx_st_reg <= TX_IDLE;
      endcase
    end
  end

  //********************************************************************
  // Receiver
  //********************************************************************
  logic       rx_active_reg;      // Inside a frame
  logic [3:0] rtick_reg;          // Ticks within bit
  logic [3:0] rbits_reg;          // Bits sampled
  logic [10:0] rsh_reg;           // Sampled bits
  logic [2:0] vote_reg;           // Three samples around centre
  logic [8:0] fifo_mem [FIFO_DEPTH];  // Data plus ninth bit
  logic       wp_reg;             // Write pointer
  logic       rp_reg;             // Read pointer
  logic [1:0] cnt_reg;            // Entries held
  logic       push;               // Character complete
  logic       pop;                // Software read
  logic [8:0] rword;              // Assembled word
  logic       rstop;              // Stop bit sampled
  logic       rpar;               // Received parity bit
  logic       shared_rx;          // Receiver line in use
  logic [3:0] rlen;               // Bits to sample after start
  logic       majority;           // Voted bit
  logic       noisy;              // Samples disagree
  logic       rnoise_reg;         // Noise seen this frame
  logic [3:0] rmid;               // Mid-bit sample tick
  // receiver has priority on the shared pin
  assign shared_rx = receiver_enable;
  assign rlen  = frame_len - 4'h1 - {3'b000, line_reg[LF_STOP2]};
  assign rmid  = {1'b0, ovs_top[3:1]};
  assign majority = (vote_reg[0] & vote_reg[1]) | (vote_reg[1] & vote_reg[2])
                  | (vote_reg[0] & vote_reg[2]);
  assign noisy = ~(&vote_reg) & (|vote_reg);
  assign rword = nine ? rsh_reg[8:0] : {1'b0, rsh_reg[7:0]};
  assign rpar  = nine ? rsh_reg[9] : rsh_reg[8];
  assign rstop = rsh_reg[rlen - 4'h1];
  assign pop   = rd_data & (cnt_reg != 2'd0);

  // Bit-level sampler; lsb first
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rx_active_reg <= 1'b0;
      rtick_reg     <= 4'h0;
      rbits_reg     <= 4'h0;
      rsh_reg       <= 11'h000;
      vote_reg      <= 3'b111;
      rnoise_reg    <= 1'b0;
    end else if (!shared_rx) begin
      rx_active_reg <= 1'b0;
    end else if (tick) begin
      vote_reg <= {vote_reg[1:0], rxtx_in};
      if (!rx_active_reg) begin
        rtick_reg  <= 4'h0;
        rbits_reg  <= 4'h0;
        rnoise_reg <= 1'b0;
        if (!rxtx_in) rx_active_reg <= 1'b1;
      end else begin
        rtick_reg <= rtick_reg + 4'h1;
        if (rtick_reg == rmid + 4'h1 && rbits_reg != 4'h0) begin
          // Shift right; the newest bit lands in the frame's last slot
          rsh_reg              <= rsh_reg >> 1;
          rsh_reg[rlen - 4'h1] <= majority;
          rnoise_reg <= rnoise_reg | noisy;
        end
        if (rtick_reg == ovs_top) begin
          rtick_reg <= 4'h0;
          rbits_reg <= rbits_reg + 4'h1;
          if (rbits_reg == rlen) rx_active_reg <= 1'b0;
        end
      end
    end
  end
  assign push = shared_rx & tick & rx_active_reg & (rtick_reg == ovs_top)
              & (rbits_reg == rlen);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end else if (!receiver_enable) begin
      wp_reg  <= 1'b0;
      rp_reg  <= 1'b0;
      cnt_reg <= 2'd0;
    end else begin
      if (push & (cnt_reg != 2'd2) & ~st_reg[ST_OVERRUN_ERROR_FLAG]) begin
        fifo_mem[wp_reg] <= rword;
        wp_reg <= ~wp_reg;
      end
      if (pop) rp_reg <= ~rp_reg;
      cnt_reg <= cnt_reg + 2'((push & (cnt_reg != 2'd2) & ~st_reg[ST_OVERRUN_ERROR_FLAG]) ? 1 : 0)
                         - 2'(pop ? 1 : 0);
    end
  end

  //********************************************************************
  // Status flags; set wins over clear
  //********************************************************************
  logic       addr_hit_reg;       // Address character seen

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg       <= STATUS_RST;
      addr_hit_reg <= 1'b0;
    end else if (!en) begin
      st_reg       <= STATUS_RST;
      addr_hit_reg <= 1'b0;
    end else begin
      // errors of each stored character, set wins
      if (seq_clr) st_reg[ST_PARITY_ERROR_FLAG:ST_FRAMING_ERROR_FLAG] <= 3'b000;
      if (push & ~st_reg[ST_OVERRUN_ERROR_FLAG] & (cnt_reg != 2'd2)) begin
        // noise set only with a real transfer
        st_reg[ST_PARITY_ERROR_FLAG:ST_FRAMING_ERROR_FLAG] <= (seq_clr ? 3'b000 : st_reg[ST_PARITY_ERROR_FLAG:ST_FRAMING_ERROR_FLAG]) | framing_error_flag_mem_in();
      end
      if (seq_clr) st_reg[ST_OVERRUN_ERROR_FLAG] <= 1'b0;
      if (push & (cnt_reg == 2'd2)) st_reg[ST_OVERRUN_ERROR_FLAG] <= 1'b1;
      // last data bit one marks an address
      if (seq_clr) addr_hit_reg <= 1'b0;
      if (push & dir_reg[DC_ADDR] & (nine ? rword[8] : rword[7])) addr_hit_reg <= 1'b1;
      // empty on transfer; idle cleared by sequence then data write
      if (st_armed_reg & wr_data) begin
        st_reg[ST_TEMPTY] <= 1'b0;
        st_reg[ST_TRANSMIT_IDLE_FLAG]  <= 1'b0;
      end
      if (tx_load | (reg_wr & (reg_addr == ADDR_DIR) & reg_wdata[DC_TRANSMITTER_ENABLE]))
        st_reg[ST_TEMPTY] <= 1'b1;
      if ((tx_st_reg == TX_IDLE) & ~thold_full_reg & ~wr_data & ~line_reg[LF_BRK])
        st_reg[ST_TRANSMIT_IDLE_FLAG] <= 1'b1;
    end
  end

  // Error bits of the incoming character
  function automatic logic [2:0] framing_error_flag_mem_in();
    framing_error_flag_mem_in = {line_reg[LF_PEN] & (rpar != par_of(rword, nine, line_reg[LF_ODD])),
                   rnoise_reg, ~rstop};
  endfunction : framing_error_flag_mem_in

  //********************************************************************
  // Read data and pins
  //********************************************************************
  logic [7:0] status_live;        // Status as software sees it
  logic       rx8_live;           // Ninth bit of oldest character
  // read-only, receiver idle and ready bits from live state
  assign status_live = {st_reg[7:4], ~rx_active_reg, cnt_reg != 2'd0,
                        st_reg[ST_TRANSMIT_IDLE_FLAG], st_reg[ST_TEMPTY]};
  assign rx8_live = (cnt_reg != 2'd0) & fifo_mem[rp_reg][8];

  // Register read mux
  always_comb begin
    unique case (reg_addr)
      ADDR_STATUS: rdata_next = status_live;
      ADDR_LINE:   rdata_next = {line_reg[7:2], rx8_live, 1'b0};
      ADDR_DIR:    rdata_next = dir_reg;
      ADDR_WIRE:   rdata_next = {7'h00, wire_reg};
      // read side; ready drops when buffer empties
      ADDR_DATA:   rdata_next = (cnt_reg != 2'd0) ? fifo_mem[rp_reg][7:0] : 8'h00;
      ADDR_BAUD:   rdata_next = baud_reg;
      default:     rdata_next = 8'h00;
    endcase
  end

  // Read data stands one cycle after the strobe
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) reg_rdata <= 8'h00;
    else if (reg_rd) reg_rdata <= rdata_next;
    else reg_rdata <= 8'h00;
  end

  assign irq = (dir_reg[DC_RIE] & ((cnt_reg != 2'd0) | addr_hit_reg | st_reg[ST_OVERRUN_ERROR_FLAG]))
             | (dir_reg[DC_TIIE] & st_reg[ST_TRANSMIT_IDLE_FLAG] & transmitter_enable)
             | (dir_reg[DC_TEIE] & st_reg[ST_TEMPTY] & transmitter_enable);

  // pin roles; float when off, pull-ups only while enabled
  assign tx_out      = tline_reg;
  assign tx_oe_b     = ~transmitter_enable;
  assign tx_pullup   = transmitter_enable;
  assign rxtx_out    = tline_reg;
  assign rxtx_oe_b   = ~(wire_reg & transmitter_enable & ~receiver_enable);
  assign rxtx_pullup = receiver_enable | (wire_reg & transmitter_enable);
endmodule : sus_uart

// ---- sus_uart_asserts.sv ----
// Purpose: Port-level checks for sus_uart
// Assumes: Control writes seen on the port decide the pin ownership
// Notes:   Pin ownership checks wait until the shadowed controls sit still two cycles
`timescale 1ns/1ps
module sus_uart_asserts
  import sus_pkg::*;
#(
  parameter int FIFO_DEPTH = 2
) (
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_b,
  // Register port
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  // Serial pins and event line
  input wire logic       tx_out,
  input wire logic       tx_oe_b,
  input wire logic       tx_pullup,
  input wire logic       rxtx_in,
  input wire logic       rxtx_out,
  input wire logic       rxtx_oe_b,
  input wire logic       rxtx_pullup,
  input wire logic       irq
);
  //********************************
  // Shadow of the pin controls
  //********************************
  logic       en_reg, transmitter_enable_reg, receiver_enable_reg, wire_reg;  // Shadowed control bits
  logic [3:0] cfg_d1, cfg_d2;                        // Delayed copies
  logic [3:0] cfg;                                   // Packed controls
  logic       steady;                                // Controls quiet
  assign cfg    = {en_reg, transmitter_enable_reg, receiver_enable_reg, wire_reg};
  assign steady = (cfg == cfg_d1) && (cfg_d1 == cfg_d2);
  // Follow writes; a disable also drops both direction enables
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {en_reg, transmitter_enable_reg, receiver_enable_reg, wire_reg} <= 4'h0;
    end else if (reg_wr && reg_addr == ADDR_LINE) begin
      en_reg <= reg_wdata[LF_EN];
      if (!reg_wdata[LF_EN]) begin
        {transmitter_enable_reg, receiver_enable_reg} <= 2'h0;
      end
    end else if (reg_wr && reg_addr == ADDR_DIR) begin
      // Enables written while disabled are dropped
      {transmitter_enable_reg, receiver_enable_reg} <= en_reg ? {reg_wdata[DC_TRANSMITTER_ENABLE], reg_wdata[DC_RECEIVER_ENABLE]} : 2'h0;
    end else if (reg_wr && reg_addr == ADDR_WIRE) begin
      wire_reg <= reg_wdata[0];
    end
  end
  // Two-cycle history of the controls
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_d1 <= 4'h0;
      cfg_d2 <= 4'h0;
    end else begin
      cfg_d1 <= cfg;
      cfg_d2 <= cfg_d1;
    end
  end
  //********************************
  // Checks
  //********************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  property p_rd_quiet; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
  property p_tx_own; steady |-> tx_oe_b == !(en_reg && transmitter_enable_reg); endproperty
  property p_float; steady && !en_reg |-> tx_oe_b && rxtx_oe_b; endproperty
  property p_pull; tx_pullup == !tx_oe_b; endproperty
  property p_duplex; steady && !wire_reg |-> rxtx_oe_b; endproperty
  property p_swm_tx;
    steady && wire_reg && en_reg && transmitter_enable_reg && !receiver_enable_reg |-> !rxtx_oe_b && rxtx_pullup;
  endproperty
  property p_swm_rx; steady && receiver_enable_reg |-> rxtx_oe_b; endproperty
  property p_mirror; rxtx_out == tx_out; endproperty
  property p_bit; $fell(tx_out) && !tx_oe_b |=> (!tx_out || tx_oe_b) [*3]; endproperty
  a_rd_quiet: assert property (p_rd_quiet) else $error("read data not quiet");
  a_tx_own: assert property (p_tx_own) else $error("tx pin ownership wrong");
  a_float: assert property (p_float) else $error("pins not floating");
  a_pull: assert property (p_pull) else $error("tx pull-up wrong");
  a_duplex: assert property (p_duplex) else $error("shared pin driven");
  a_swm_tx: assert property (p_swm_tx) else $error("shared pin not sending");
  a_swm_rx: assert property (p_swm_rx) else $error("receiver lost priority");
  a_mirror: assert property (p_mirror) else $error("pins differ");
  a_bit: assert property (p_bit) else $error("start bit too short");
  c_swm: cover property (!rxtx_oe_b);
  c_start: cover property ($fell(tx_out) && !tx_oe_b);
  c_ovr: cover property (reg_rd && reg_addr == ADDR_STATUS ##1 reg_rdata[ST_OVERRUN_ERROR_FLAG]);
endmodule : sus_uart_asserts

bind sus_uart sus_uart_asserts #(.FIFO_DEPTH(FIFO_DEPTH)) sus_uart_asserts_i (
  .clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_out(tx_out),
  .tx_oe_b(tx_oe_b), .tx_pullup(tx_pullup), .rxtx_in(rxtx_in), .rxtx_out(rxtx_out),
  .rxtx_oe_b(rxtx_oe_b), .rxtx_pullup(rxtx_pullup), .irq(irq));

// ---- sus_peer.sv ----
// Purpose: Far-end serial device for the transceiver bench
// Assumes: Bit time BIT clocks; line rests high between frames
// Notes:   Frames are given whole, start bit in bit 0
`timescale 1ns/1ps
module sus_peer #(
  parameter int BIT = 16
) (
  // Clock
  input wire logic clock,
  // Serial lines
  input wire logic line_in,
  output logic     line_out
);
  initial line_out = 1'b1;
  task automatic send(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++) begin
      line_out <= f[i];
      repeat (BIT) @(posedge clock);
    end
    line_out <= 1'b1;
    // Two idle clocks so the far end has stored the frame on return
    repeat (2) @(posedge clock);
  endtask : send
  // lsb first capture; nine samples, the last is bit nine or stop
  task automatic grab(output logic [8:0] b, output bit ok);
    int k;
    k = 0;
    while (line_in && k < 2000) begin
      @(posedge clock);
      k++;
    end
    ok = !line_in;
    repeat (BIT / 2 + BIT) @(posedge clock);
    for (int i = 0; i < 9; i++) begin
      b[i] = line_in;
      repeat (BIT) @(posedge clock);
    end
  endtask : grab
endmodule : sus_peer

// ---- sus_uart_test.sv ----
// Purpose: Self-checking bench for sus_uart
// Assumes: Divisor 0, slow mode: 16 clocks a bit
// Notes:   Shared pin level resolved from both drivers
`timescale 1ns/1ps
module sus_uart_test;
  import sus_pkg::*;
  logic       clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, peer_line;
  logic [2:0] reg_addr = 3'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [8:0] d;
  logic       tx_out, tx_oe_b, tx_pullup, rxtx_in, rxtx_out, rxtx_oe_b, rxtx_pullup, irq;
  int         mismatches = 0, n_compared = 0;
  bit         ok;
  always #25 clock = ~clock;
  assign rxtx_in = rxtx_oe_b ? peer_line : rxtx_out;
  sus_uart sus_uart_i (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .tx_out(tx_out), .tx_oe_b(tx_oe_b), .tx_pullup(tx_pullup), .rxtx_in(rxtx_in),
    .rxtx_out(rxtx_out), .rxtx_oe_b(rxtx_oe_b), .rxtx_pullup(rxtx_pullup), .irq(irq));
  sus_peer #(.BIT(16)) sus_peer_i (.clock(clock), .line_in(tx_oe_b ? 1'b1 : tx_out),
    .line_out(peer_line));
  //********************************
  // Bus and check helpers
  //********************************
  task automatic close_out;
    if (mismatches == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask : wr
  task automatic rd(input logic [2:0] a);
    reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = {1'b0, reg_rdata};
    @(posedge clock);
  endtask : rd
  task automatic get(input logic [8:0] e);
    sus_peer_i.grab(d, ok);
    if (!ok) begin
      mismatches++;
      $display("ERROR %0t no frame", $time);
      close_out();
    end else chk(d, e);
  endtask : get
  //********************************
  // Scenarios
  //********************************
  task automatic t_reset;
    rd(ADDR_STATUS); chk(d, STATUS_RST);
    wr(ADDR_STATUS, 8'hf4); rd(ADDR_STATUS); chk(d, STATUS_RST);
    rd(3'h7); chk(d, 9'h000);
  endtask : t_reset
  task automatic t_tx;
    wr(ADDR_BAUD, 8'h00); wr(ADDR_LINE, 8'h80); wr(ADDR_DIR, 8'h80);
    rd(ADDR_STATUS); chk(d & 9'h003, 9'h003);
    wr(ADDR_DATA, 8'ha5); get(9'h1a5);
    repeat (32) @(posedge clock);
    rd(ADDR_STATUS); chk(d & 9'h003, 9'h003);
    wr(ADDR_LINE, 8'hc0); wr(ADDR_DATA, 8'h0f); get(9'h00f);
    repeat (48) @(posedge clock);
  endtask : t_tx
  task automatic t_rx;
    wr(ADDR_DIR, 8'h44); sus_peer_i.send({1'b1, 2'b11, 8'h00, 1'b0}, 11);
    rd(ADDR_STATUS); rd(ADDR_LINE); chk(d & 9'h002, 9'h002);
    rd(ADDR_DATA); wr(ADDR_LINE, 8'h80); sus_peer_i.send({3'b111, 8'h3c, 1'b0}, 10);
    rd(ADDR_STATUS); chk(d & 9'h004, 9'h004);
    chk({8'h00, irq}, 9'h001);
    rd(ADDR_DATA); chk(d, 9'h03c);
    rd(ADDR_STATUS); chk(d & 9'h004, 9'h000);
    chk({8'h00, irq}, 9'h000);
  endtask : t_rx
  task automatic t_err;
    for (int i = 0; i < 2; i++) begin
      wr(ADDR_LINE, i ? 8'hb0 : 8'ha0); sus_peer_i.send({3'b110, 8'h01, 1'b0}, 11);
      rd(ADDR_STATUS); chk(d & 9'h080, i ? 9'h000 : 9'h080);
      rd(ADDR_DATA); rd(ADDR_STATUS); chk(d & 9'h080, 9'h000);
    end
    wr(ADDR_LINE, 8'h80); sus_peer_i.send({3'b110, 8'h55, 1'b0}, 10);
    rd(ADDR_STATUS); chk(d & 9'h020, 9'h020);
    rd(ADDR_DATA); rd(ADDR_STATUS); chk(d & 9'h020, 9'h000);
  endtask : t_err
  task automatic t_ovr;
    for (int i = 0; i < 4; i++) sus_peer_i.send({3'b111, 8'h10 + 8'(i), 1'b0}, 10);
    rd(ADDR_STATUS); chk(d & 9'h010, 9'h010);
    rd(ADDR_DATA); chk(d, 9'h010);
    rd(ADDR_DATA); chk(d, 9'h011);
    wr(ADDR_DIR, 8'h54); sus_peer_i.send({3'b111, 8'h80, 1'b0}, 10);
    rd(ADDR_DATA); chk(d, 9'h080); chk({8'h00, irq}, 9'h001);
    rd(ADDR_STATUS); rd(ADDR_DATA); chk({8'h00, irq}, 9'h000);
  endtask : t_ovr
  task automatic t_swm;
    wr(ADDR_WIRE, 8'h01); wr(ADDR_DIR, 8'h80);
    chk({8'h00, rxtx_oe_b}, 9'h000);
    wr(ADDR_DATA, 8'h5a); get(9'h15a);
    repeat (32) @(posedge clock);
    wr(ADDR_DIR, 8'hc0); chk({8'h00, rxtx_oe_b}, 9'h001);
    wr(ADDR_LINE, 8'h00); rd(ADDR_STATUS); chk(d, STATUS_RST);
    chk({7'h00, tx_oe_b, rxtx_oe_b}, 9'h003);
  endtask : t_swm
  initial begin
    repeat (5) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    t_reset(); t_tx(); t_rx(); t_err(); t_ovr(); t_swm();
    close_out();
  end
endmodule : sus_uart_test
